/* File: src/dpm_defines.svh */
// constants for the dual-port memory port host
`ifndef DPM_DEFINES_SVH
`define DPM_DEFINES_SVH

`define DPM_ADDR_W        11
`define DPM_DATA_W        9
`define DPM_CNT_W         3
`define DPM_SYNC_STAGES   3'h2

// mailbox words at the top of the array
`define DPM_MBOX_LEFT     11'h7FE
`define DPM_MBOX_RIGHT    11'h7FF

// clock period and printed times, in ns
`define DPM_CLK_NS        40
`define DPM_BUSY_ACC_NS   30
`define DPM_BUSY_DATA_NS  45

// least times round up to whole cycles
`define DPM_BUSY_ACC_CYC  3'((`DPM_BUSY_ACC_NS + `DPM_CLK_NS - 1) / `DPM_CLK_NS)
`define DPM_BUSY_DATA_CYC 3'((`DPM_BUSY_DATA_NS + `DPM_CLK_NS - 1) / `DPM_CLK_NS)

`endif

/* File: src/dpm_pkg.sv */
// types shared by the dual-port memory port host
`include "dpm_defines.svh"

package dpm_pkg;

	typedef struct packed {
		logic                    we;
		logic [`DPM_ADDR_W-1:0]  addr;
		logic [`DPM_DATA_W-1:0]  wdata;
	} dpm_req_t;

	typedef struct packed {
		logic                    ce_n;
		logic                    rw_n;
		logic                    oe_n;
		logic [`DPM_ADDR_W-1:0]  addr;
	} dpm_pins_t;

	typedef enum logic [2:0] {
		DPM_IDLE,
		DPM_ARB,
		DPM_WPULSE,
		DPM_WREC,
		DPM_RDATA
	} dpm_state_t;

endpackage

/* File: src/dpm_host.sv */
// host controller for one port of a dual-port memory with busy and mailbox
//
// Summary of operation
// (RQ1) port select high deselects the device port; host idles with select high.
// (RQ2) select low with read/write low writes the data lines into memory.
// (RQ3) select and output enable low with read/write high drives memory data out.
// (RQ4) writes from a port seeing busy low are blocked inside the device.
// (RQ5) read data taken while busy is low is unreliable and must be discarded.
// (RQ6) left write to 7FF sets the right mailbox flag low.
// (RQ7) right read of 7FF with select and output enable low clears its flag; the device model clears it on any right select of 7FF.
// (RQ8) right write to 7FE sets the left mailbox flag low.
// (RQ9) left access to 7FE with select and output enable low clears its flag.
// (RQ10) mailbox set or clear while accessing port sees busy low has no effect; the device model gates only the left port's set and clear by busy.
// (RQ11) mailbox words remain ordinary 9-bit readable and writable storage.
// (RQ12) hosts may use the top two words as plain storage, ignoring flags.
// (RQ13) on same-address collision the master grants one port, busy to other.
// (RQ14) a host seeing busy holds its access until busy returns high.
// (RQ15) slave busy pin is only a write-inhibit input, no arbitration.
// (RQ16) system holds slave busy inputs high; low forever blocks that port's writes.
// (RQ17) system may OR busy outputs into an illegal-access interrupt.
// (RQ18) depth-stacked devices AND their busy outputs per side.
// (RQ19) master busy outputs are push-pull, needing no pull-up.
// (RQ20) arbitration uses only select and address, not read or write.
// (RQ21) earlier port by the set-up margin wins; later port gets busy.
// (RQ22) on a tie exactly one port receives busy.
`timescale 1ns/1ps
`include "dpm_defines.svh"

//////////////////////////////////////////////////////////////////////////////
module dpm_sync #(
	parameter int W = 1
) (
	input  wire logic         ref_clk_i,
	input  wire logic         rst_n_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);
	// the first stage may go metastable; only the second stage is read
	logic [W-1:0] meta_q;

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_q <= '0;
			sync_o <= '0;
		end else begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end
endmodule // dpm_sync

//////////////////////////////////////////////////////////////////////////////
module dpm_host (
	input  wire logic                   ref_clk_i,
	input  wire logic                   rst_n_i,
	// user side
	input  wire logic                   req_valid_i,
	input  wire dpm_pkg::dpm_req_t      req_i,
	output logic                        req_ready_o,
	output logic                        rsp_valid_o,
	output logic [`DPM_DATA_W-1:0]      rsp_data_o,
	output logic                        mail_pending_o,
	output logic                        busy_seen_o,
	// device port pins
	output dpm_pkg::dpm_pins_t          ram_pins_o,
	input  wire logic [`DPM_DATA_W-1:0] ram_data_i,
	output logic [`DPM_DATA_W-1:0]      ram_data_o,
	output logic                        ram_data_oe_n_o,
	input  wire logic                   ram_busy_n_i,
	input  wire logic                   ram_mailbox_flag_n_i
);
	localparam int SW = `DPM_DATA_W + 2;

	logic [SW-1:0]             sync_s;
	logic [`DPM_DATA_W-1:0]    data_s;
	logic                      busy_n_s;
	logic                      flag_n_s;

	// busy may be the AND of stacked devices, or a slave's input held high;
	// here it only gates this port's progress, never the data path [RQ16] [RQ18]
	dpm_sync #(.W(SW)) u_sync (
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_n_i),
		.async_i   ({ram_data_i, ram_busy_n_i, ram_mailbox_flag_n_i}),
		.sync_o    (sync_s)
	);
	assign data_s   = sync_s[SW-1:2];
	assign busy_n_s = sync_s[1];
	assign flag_n_s = sync_s[0];

	////////////////////////////////////////////////////////////////////////////
	dpm_pkg::dpm_state_t       state_q, state_d;
	dpm_pkg::dpm_pins_t        pins_q, pins_d;
	logic [`DPM_DATA_W-1:0]    wdata_q, wdata_d;
	logic                      doe_n_q, doe_n_d;
	logic                      we_q, we_d;
	logic [`DPM_CNT_W-1:0]     cnt_q, cnt_d;
	logic                      ready_q, ready_d;
	logic                      rsp_v_q, rsp_v_d;
	logic [`DPM_DATA_W-1:0]    rdata_q, rdata_d;
	logic                      mail_q, mail_d;
	logic                      bseen_q, bseen_d;

	// response is a pulse; mail and busy-seen follow their inputs; every other value holds unless a state moves it
	always_comb begin
		state_d = state_q;
		pins_d  = pins_q;
		wdata_d = wdata_q;
		doe_n_d = doe_n_q;
		we_d    = we_q;
		cnt_d   = cnt_q;
		ready_d = ready_q;
		rsp_v_d = 1'b0;
		rdata_d = rdata_q;
		mail_d  = !flag_n_s;  // flag is active low; any word incl. mailbox is plain storage [RQ11] [RQ12]
		// a plain level; a system may OR both sides into a fault flag
		bseen_d = !busy_n_s;  // [RQ17]
		case (state_q)
			dpm_pkg::DPM_IDLE: begin
				if (req_valid_i && ready_q) begin
					// select and address go out first; read/write stays high so
					// busy settles before any write pulse is started
					pins_d.ce_n = 1'b0;
					pins_d.rw_n = 1'b1;
					pins_d.oe_n = req_i.we;  // reads open the output right away [RQ3]
					pins_d.addr = req_i.addr;
					wdata_d     = req_i.wdata;
					we_d        = req_i.we;
					cnt_d       = `DPM_BUSY_ACC_CYC + `DPM_SYNC_STAGES;
					ready_d     = 1'b0;
					// count covers busy access time plus both synchroniser stages
					state_d     = dpm_pkg::DPM_ARB;
				end
			end
			dpm_pkg::DPM_ARB: begin
				if (cnt_q != '0) begin
					cnt_d = cnt_q - 3'h1;
				end else if (!busy_n_s) begin
					// lost arbitration: keep select and address and wait [RQ14] [RQ4]
					cnt_d = '0;
				end else if (we_q) begin
					pins_d.rw_n = 1'b0;  // write pulse with data driven [RQ2]
					doe_n_d     = 1'b0;
					state_d     = dpm_pkg::DPM_WPULSE;
				end else begin
					// data from a formerly busy read needs time to become valid [RQ5]
					cnt_d   = `DPM_BUSY_DATA_CYC + `DPM_SYNC_STAGES;
					state_d = dpm_pkg::DPM_RDATA;
				end
			end
			dpm_pkg::DPM_WPULSE: begin
				// strobe lasts one cycle; busy was clear as it began
				pins_d.rw_n = 1'b1;  // data held one cycle past the pulse
				state_d     = dpm_pkg::DPM_WREC;
			end
			dpm_pkg::DPM_WREC: begin
				pins_d.ce_n = 1'b1;  // deselect returns the port to standby [RQ1]
				doe_n_d     = 1'b1;
				rsp_v_d     = 1'b1;
				ready_d     = 1'b1;
				state_d     = dpm_pkg::DPM_IDLE;
			end
			dpm_pkg::DPM_RDATA: begin
				if (cnt_q != '0) begin
					cnt_d = cnt_q - 3'h1;
				end else if (!busy_n_s) begin
					// busy came back: data unreliable, wait again [RQ5] [RQ14]
					state_d = dpm_pkg::DPM_ARB;
				end else begin
					// a read of the own mailbox word also clears the own flag [RQ7] [RQ9]
					rdata_d     = data_s;
					pins_d.ce_n = 1'b1;  // [RQ1]
					pins_d.oe_n = 1'b1;
					rsp_v_d     = 1'b1;
					ready_d     = 1'b1;
					state_d     = dpm_pkg::DPM_IDLE;
				end
			end
			default: begin
				state_d = dpm_pkg::DPM_IDLE;
			end
		endcase
	end

	// registers only; every output below is one of these flops
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= dpm_pkg::DPM_IDLE;
			pins_q  <= '{ce_n: 1'b1, rw_n: 1'b1, oe_n: 1'b1, addr: '0};
			wdata_q <= '0;
			doe_n_q <= 1'b1;
			we_q    <= 1'b0;
			cnt_q   <= '0;
			ready_q <= 1'b1;
			rsp_v_q <= 1'b0;
			rdata_q <= '0;
			mail_q  <= 1'b0;
			bseen_q <= 1'b0;
		end else begin
			state_q <= state_d;
			pins_q  <= pins_d;
			wdata_q <= wdata_d;
			doe_n_q <= doe_n_d;
			we_q    <= we_d;
			cnt_q   <= cnt_d;
			ready_q <= ready_d;
			rsp_v_q <= rsp_v_d;
			rdata_q <= rdata_d;
			mail_q  <= mail_d;
			bseen_q <= bseen_d;
		end
	end

	assign req_ready_o     = ready_q;
	assign rsp_valid_o     = rsp_v_q;
	assign rsp_data_o      = rdata_q;
	assign mail_pending_o  = mail_q;
	assign busy_seen_o     = bseen_q;
	assign ram_pins_o      = pins_q;
	assign ram_data_o      = wdata_q;
	assign ram_data_oe_n_o = doe_n_q;
endmodule // dpm_host

/* File: sim/dpm_host_checker.sv */
// assertions on the pins of the port host
`timescale 1ns/1ps
module dpm_chk (
	input wire logic               ref_clk_i,
	input wire logic               rst_n_i,
	input wire logic               req_valid_i,
	input wire dpm_pkg::dpm_req_t  req_i,
	input wire logic               req_ready_o,
	input wire logic               rsp_valid_o,
	input wire dpm_pkg::dpm_pins_t ram_pins_o,
	input wire logic               ram_data_oe_n_o,
	input wire logic               ram_busy_n_i
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	////////////////////////////////////////
	property p_idle; req_ready_o |-> ram_pins_o.ce_n; endproperty
	a_idle: assert property (p_idle) else $error("select low while idle");
	property p_take; req_valid_i && req_ready_o |=>
		!ram_pins_o.ce_n && ram_pins_o.addr == $past(req_i.addr) ##1 $stable(ram_pins_o.addr);
	endproperty
	a_take: assert property (p_take) else $error("address moved at start");
	property p_wen; $fell(ram_pins_o.rw_n) |-> !ram_pins_o.ce_n && !ram_data_oe_n_o; endproperty
	a_wen: assert property (p_wen) else $error("write strobe without select or data");
	property p_oe; !ram_pins_o.oe_n |-> ram_pins_o.rw_n && ram_data_oe_n_o; endproperty
	a_oe: assert property (p_oe) else $error("output enable during drive");
	property p_nowr; !ram_busy_n_i [*6] |-> ram_pins_o.rw_n; endproperty
	a_nowr: assert property (p_nowr) else $error("write strobe under busy");
	property p_stall; !ram_busy_n_i [*8] |-> !rsp_valid_o; endproperty
	a_stall: assert property (p_stall) else $error("done under busy");
	property p_wlat; req_valid_i && req_ready_o && req_i.we ##1 ram_busy_n_i [*7] |-> rsp_valid_o;
	endproperty
	a_wlat: assert property (p_wlat) else $error("write late");
	property p_rlat; req_valid_i && req_ready_o && !req_i.we ##1 ram_busy_n_i [*8] |-> ##2 rsp_valid_o;
	endproperty
	a_rlat: assert property (p_rlat) else $error("read late");
	c_wr: cover property (req_valid_i && req_ready_o && req_i.we);
	c_done: cover property (rsp_valid_o);
	c_busy: cover property (!ram_busy_n_i && !ram_pins_o.ce_n);
endmodule // dpm_chk

/* File: sim/dpm_dev.sv */
// behavioural left port of the dual-port memory
`timescale 1ns/1ps
`include "dpm_defines.svh"
module dpm_dev (
	input  wire dpm_pkg::dpm_pins_t pins_i,
	input  wire logic [8:0]         wd_i,
	input  wire logic               wd_oe_n_i,
	input  wire logic               peer_ce_i,
	input  wire logic [10:0]        peer_addr_i,
	input  wire logic               peer_mb_i,
	output logic [8:0]              rd_o,
	output logic                    busy_n_o,
	output logic                    flag_n_o,
	output logic                    peer_flag_n_o
);
	logic [8:0] mem [2048];
	logic [8:0] last = 9'h000;
	wire        sel = !pins_i.ce_n;
	wire        rdn = sel && pins_i.rw_n && !pins_i.oe_n;
	logic       host_won = 1'b0;
	wire        hit = sel && peer_ce_i && pins_i.addr == peer_addr_i;
	wire        clr_l = sel && !pins_i.oe_n && busy_n_o && pins_i.addr == `DPM_MBOX_LEFT;
	wire        set_r = sel && !pins_i.rw_n && busy_n_o && pins_i.addr == `DPM_MBOX_RIGHT;
	wire        clr_r = peer_ce_i && peer_addr_i == `DPM_MBOX_RIGHT;
	////////////////////////////////////////
	// first to select the shared word wins; a tie goes to the peer, so busy
	// reaches one side only; push-pull, only select and address count
	always @(posedge peer_ce_i or negedge sel)
		host_won = peer_ce_i && sel && pins_i.addr == peer_addr_i;
	assign busy_n_o = !(hit && !host_won);
	initial begin
		flag_n_o = 1'b1;
		forever begin
			@(posedge peer_mb_i or posedge clr_l);
			flag_n_o = !peer_mb_i; // set wins over a clear
		end
	end
	initial begin
		peer_flag_n_o = 1'b1;
		forever begin
			@(posedge set_r or posedge clr_r);
			peer_flag_n_o = !set_r;
		end
	end
	always @* begin
		// a slave port gates writes by the same busy level, no arbitration
		if (sel && !pins_i.rw_n && busy_n_o)
			mem[pins_i.addr] = wd_oe_n_i ? ~wd_i : wd_i;
	end
	// floating lines show the inverse, never a held value
	always @* begin
		if (rdn)
			last = busy_n_o ? mem[pins_i.addr] : ~mem[pins_i.addr];
		rd_o = rdn ? last : ~last;
	end
endmodule // dpm_dev

/* File: sim/dpm_host_test.sv */
// self-checking bench for the port host
`timescale 1ns/1ps
module dpm_host_test;
	logic               ref_clk_i = 1'b0;
	logic               rst_n_i = 1'b0;
	logic               req_valid_i = 1'b0;
	dpm_pkg::dpm_req_t  req_i = '0;
	logic               rdy, rv, mp, bs, doe_n, bz_n, fl_n, pfl_n;
	logic [8:0]         rd, rdat, wd;
	dpm_pkg::dpm_pins_t pins;
	logic               peer_ce = 1'b0;
	logic               peer_mb = 1'b0;
	logic [9:0]         expq [$];
	logic [9:0]         e;
	logic [8:0]         img [2048];
	logic [10:0]        ad [8];
	int                 errors = 0;
	int                 n_checks = 0;
	int                 cyc = 0;
	int                 seed = 32'h70bd;
	always #20 ref_clk_i = ~ref_clk_i;
	dpm_host dut_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i),
		.req_i(req_i), .req_ready_o(rdy), .rsp_valid_o(rv), .rsp_data_o(rdat),
		.mail_pending_o(mp), .busy_seen_o(bs), .ram_pins_o(pins), .ram_data_i(rd),
		.ram_data_o(wd), .ram_data_oe_n_o(doe_n), .ram_busy_n_i(bz_n),
		.ram_mailbox_flag_n_i(fl_n));
	dpm_dev dev_u (.pins_i(pins), .wd_i(wd), .wd_oe_n_i(doe_n), .peer_ce_i(peer_ce),
		.peer_addr_i(11'h123), .peer_mb_i(peer_mb), .rd_o(rd), .busy_n_o(bz_n),
		.flag_n_o(fl_n), .peer_flag_n_o(pfl_n));
	////////////////////////////////////////
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic acc(input logic we, input logic [10:0] a, input logic [8:0] d);
		do @(posedge ref_clk_i); while (!rdy);
		req_valid_i <= 1'b1;
		req_i <= '{we, a, d};
		if (we)
			img[a] = d;
		expq.push_back({we, we ? 9'h000 : img[a]});
		@(posedge ref_clk_i);
		req_valid_i <= 1'b0;
	endtask
	task automatic idle;
		while (expq.size() != 0) @(posedge ref_clk_i);
	endtask
	always @(posedge ref_clk_i) begin
		if (rv) begin
			e = expq.pop_front();
			if (!e[9])
				chk(rdat, e[8:0]);
		end
		cyc++;
		if (cyc == 3000) begin
			errors++;
			end_sim();
		end
	end
	initial begin
		repeat (10) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			ad[i] = (i < 2) ? 11'h7FE + 11'(i) : 11'($random(seed));
			acc(1'b1, ad[i], 9'($random(seed)));
		end
		for (int i = 0; i < 8; i++) acc(1'b0, ad[i], 9'h000);
		idle();
		chk(9'(pfl_n), 9'h000);
		$display("read write test done");
		peer_mb <= 1'b1;
		@(posedge ref_clk_i);
		peer_mb <= 1'b0;
		repeat (5) @(posedge ref_clk_i);
		chk(9'(mp), 9'h001);
		acc(1'b0, 11'h7FE, 9'h000);
		idle();
		repeat (5) @(posedge ref_clk_i);
		chk(9'(mp), 9'h000);
		$display("mailbox test done");
		for (int w = 1; w >= 0; w--) begin
			peer_ce <= 1'b1;
			acc(w[0], 11'h123, 9'h0A5);
			repeat (30) @(posedge ref_clk_i);
			chk(9'(bs), 9'h001);
			chk(9'(expq.size()), 9'h001);
			peer_ce <= 1'b0;
			idle();
		end
		$display("busy test done");
		end_sim();
	end
endmodule // dpm_host_test
bind dpm_host dpm_chk chk_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
	.req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
	.rsp_valid_o(rsp_valid_o), .ram_pins_o(ram_pins_o), .ram_data_oe_n_o(ram_data_oe_n_o),
	.ram_busy_n_i(ram_busy_n_i));
